// ### include/sfl_pkg.sv
`default_nettype none
package sfl_pkg;

  // opcodes seen on the serial link
  localparam logic [7:0] OP_DUAL_OUT_READ = 8'h3b;
  localparam logic [7:0] OP_DUAL_IO_READ = 8'hbb;
  localparam logic [7:0] OP_QUAD_OUT_READ = 8'h6b;
  localparam logic [7:0] OP_QUAD_IO_READ = 8'heb;
  localparam logic [7:0] OP_QUAD_WORD_READ = 8'he7;
  localparam logic [7:0] OP_QUAD_OCTAL_READ = 8'he3;
  localparam logic [7:0] OP_RESET_ENABLE = 8'h66;
  localparam logic [7:0] OP_RESET = 8'h99;
  localparam logic [7:0] OP_VOLATILE_WREN = 8'h50;
  localparam logic [7:0] OP_WRITE_STATUS = 8'h01;

  // lane width codes
  localparam logic [1:0] LW_ONE = 2'h0;
  localparam logic [1:0] LW_TWO = 2'h1;
  localparam logic [1:0] LW_FOUR = 2'h2;

  // bit and cycle counts of the command phases
  localparam logic [5:0] OPCODE_LAST = 6'h07;
  localparam logic [5:0] BYTE_BITS = 6'h08;
  localparam logic [5:0] ADDR_BITS = 6'h18;
  localparam logic [5:0] ADDR_MODE_BITS = 6'h20;
  localparam logic [3:0] DUMMY_NONE = 4'h0;
  localparam logic [3:0] DUMMY_WORD = 4'h2;
  localparam logic [3:0] DUMMY_QUAD_IO = 4'h4;
  localparam logic [3:0] DUMMY_OUT = 4'h8;

  // data buffer between the system side and the link
  localparam int unsigned FIFO_DEPTH = 2;
  localparam int unsigned FIFO_WIDTH = 8;
  localparam logic [7:0] UNDERRUN_BYTE = 8'hff;
  localparam logic [1:0] PTR_RESET = 2'h0;

  typedef enum logic [2:0] {
    ST_OPCODE = 3'h0,
    ST_ADDR = 3'h1,
    ST_DUMMY = 3'h2,
    ST_DATA = 3'h3,
    ST_STATUS = 3'h4,
    ST_IGNORE = 3'h5
  } sfl_link_state_t;

  typedef enum logic [1:0] {
    EV_OPCODE = 2'h0,
    EV_READ = 2'h1,
    EV_STATUS = 2'h2,
    EV_REFUSED = 2'h3
  } sfl_event_kind_t;

  typedef struct packed {
    sfl_event_kind_t kind;
    logic [7:0] opcode;
    logic [23:0] payload;
  } sfl_event_t;

  typedef struct packed {
    logic is_read;
    logic quad;
    logic has_mode;
    logic [1:0] addr_lw;
    logic [1:0] data_lw;
    logic [3:0] dummy;
  } sfl_op_info_t;

endpackage
`default_nettype wire

// ### logic/sfl_lane_front.sv
`timescale 1ns/10ps
`default_nettype none
// Contract
// - The link works only with a host in clock mode 0 or mode 3.
// - Input bits are sampled on the rising link clock edge and output bits are driven on the falling edge.
// - Command cycles are counted falling edge to falling edge, the first one in mode 0 starting at chip select fall.
// - Dual-output and dual address-and-data fast reads return data two bits per clock.
// - In two-lane commands lanes zero and one are bidirectional, driven by whichever side transfers.
// - Quad-output and quad address-and-data fast reads move four bits per clock.
// - Word read and octal word read on four lanes are accepted as quad commands.
// - In four-lane commands the protect and pause pins become lanes two and three.
// - Four-lane commands work only once the four-lane enable bit is set.
// - Software reset is reset-enable immediately followed by reset, both opcodes sent on lane zero.
// - Status one starts from its non-volatile value and a volatile copy may override it after volatile write enable.
// - Pause on lane three is available only in single-lane and two-lane operation.
// - With four-lane enable set the pause pin is purely a data lane.
module sfl_lane_front (
  input wire logic clock_in, // system clock, 25 MHz
  input wire logic reset_in, // synchronous reset, active high
  input wire logic link_clk_in, // serial clock from the host
  input wire logic chip_sel_n_in, // chip select, active low
  input wire logic [3:0] lane_in, // data_lane_zero..three pin levels
  output logic [3:0] lane_out, // lane drive values
  output logic [3:0] lane_oe_out, // lane drive enables, high drives
  input wire logic four_lane_enable_in, // non-volatile four-lane enable bit
  input wire logic [7:0] sr1_nonvolatile_in, // stored status one value
  input wire logic rd_data_valid_in, // read byte offered
  input wire logic [7:0] rd_data_in, // read byte
  output logic rd_data_ready_out, // buffer can take a byte
  output logic rd_req_out, // read command seen, pulse
  output logic [7:0] rd_opcode_out, // opcode of last read
  output logic [23:0] rd_addr_out, // address of last read
  output logic soft_reset_out, // software reset, pulse
  output logic [7:0] sr1_out, // active status one value
  output logic sr1_volatile_out, // volatile copy in force
  output logic sr1_nv_wr_out, // non-volatile status write, pulse
  output logic [7:0] sr1_nv_data_out, // data for that write
  output logic refused_out, // four-lane read refused, pulse
  output logic write_protect_n_out, // protect pin level, low protects
  output logic pause_out // pause requested on lane three
);

  typedef struct packed {
    sfl_pkg::sfl_link_state_t state;
    logic [5:0] cnt;
    logic [31:0] shift;
    logic [7:0] out_sr;
    sfl_pkg::sfl_op_info_t info;
  } sfl_frame_t;

  typedef struct packed {
    logic rst_meta;
    logic rst_sync;
    logic qe_meta;
    logic qe_sync;
    logic [1:0] wg_meta;
    logic [1:0] wg_sync;
    logic [1:0] rd_gray;
    logic ev_toggle;
    sfl_pkg::sfl_event_t ev;
  } sfl_keep_t;

  typedef struct packed {
    logic [3:0] lanes;
    logic [3:0] oe;
  } sfl_pins_t;

  typedef struct packed {
    logic tog_meta;
    logic tog_sync;
    logic tog_seen;
    logic [1:0] rg_meta;
    logic [1:0] rg_sync;
    logic [1:0] wgray;
    logic [sfl_pkg::FIFO_DEPTH-1:0][sfl_pkg::FIFO_WIDTH-1:0] mem;
    logic fifo_ready;
    logic [1:0] pin_meta;
    logic [1:0] pin_sync;
    logic rst_armed;
    logic vol_armed;
    logic load_pending;
    logic [7:0] sr1;
    logic vol_active;
    logic rd_req;
    logic [7:0] rd_opcode;
    logic [23:0] rd_addr;
    logic soft_reset;
    logic nv_wr;
    logic [7:0] nv_data;
    logic refused;
    logic wp_n;
    logic pause;
  } sfl_sys_t;

  sfl_frame_t frame_ff;
  sfl_frame_t nxt_frame;
  sfl_keep_t keep_ff;
  sfl_keep_t nxt_keep;
  sfl_pins_t pins_ff;
  sfl_pins_t nxt_pins;
  sfl_sys_t sys_ff;
  sfl_sys_t nxt_sys;
  logic paused;
  logic fifo_empty;
  logic [7:0] head_byte;
  logic [5:0] step;

  // command table: lane widths, mode byte and dummy clocks per read opcode
  function automatic sfl_pkg::sfl_op_info_t op_decode(input logic [7:0] op);
    sfl_pkg::sfl_op_info_t i;
    i = '0;
    i.addr_lw = sfl_pkg::LW_ONE;
    i.data_lw = sfl_pkg::LW_ONE;
    i.dummy = sfl_pkg::DUMMY_NONE;
    case (op)
      sfl_pkg::OP_DUAL_OUT_READ:
      begin
        i.is_read = 1'b1;
        i.data_lw = sfl_pkg::LW_TWO;
        i.dummy = sfl_pkg::DUMMY_OUT;
      end
      sfl_pkg::OP_DUAL_IO_READ:
      begin
        i.is_read = 1'b1;
        i.has_mode = 1'b1;
        i.addr_lw = sfl_pkg::LW_TWO;
        i.data_lw = sfl_pkg::LW_TWO;
      end
      sfl_pkg::OP_QUAD_OUT_READ:
      begin
        i.is_read = 1'b1;
        i.quad = 1'b1;
        i.data_lw = sfl_pkg::LW_FOUR;
        i.dummy = sfl_pkg::DUMMY_OUT;
      end
      sfl_pkg::OP_QUAD_IO_READ:
      begin
        i.is_read = 1'b1;
        i.quad = 1'b1;
        i.has_mode = 1'b1;
        i.addr_lw = sfl_pkg::LW_FOUR;
        i.data_lw = sfl_pkg::LW_FOUR;
        i.dummy = sfl_pkg::DUMMY_QUAD_IO;
      end
      sfl_pkg::OP_QUAD_WORD_READ:
      begin
        i.is_read = 1'b1;
        i.quad = 1'b1;
        i.has_mode = 1'b1;
        i.addr_lw = sfl_pkg::LW_FOUR;
        i.data_lw = sfl_pkg::LW_FOUR;
        i.dummy = sfl_pkg::DUMMY_WORD;
      end
      sfl_pkg::OP_QUAD_OCTAL_READ:
      begin
        i.is_read = 1'b1;
        i.quad = 1'b1;
        i.has_mode = 1'b1;
        i.addr_lw = sfl_pkg::LW_FOUR;
        i.data_lw = sfl_pkg::LW_FOUR;
      end
      default:
      begin
        i.is_read = 1'b0;
      end
    endcase
    return i;
  endfunction

  // bits moved per clock for a lane width
  function automatic logic [5:0] lane_step(input logic [1:0] lw);
    case (lw)
      sfl_pkg::LW_TWO: lane_step = 6'h02;
      sfl_pkg::LW_FOUR: lane_step = 6'h04;
      default: lane_step = 6'h01;
    endcase
  endfunction

  // shift lane bits in, highest lane is the most significant bit
  function automatic logic [31:0] shift_in(input logic [31:0] s, input logic [1:0] lw, input logic [3:0] p);
    case (lw)
      sfl_pkg::LW_TWO: shift_in = {s[29:0], p[1:0]};
      sfl_pkg::LW_FOUR: shift_in = {s[27:0], p};
      default: shift_in = {s[30:0], p[0]};
    endcase
  endfunction

  function automatic logic [1:0] bin2gray(input logic [1:0] b);
    bin2gray = {b[1], b[1] ^ b[0]};
  endfunction

  function automatic logic [1:0] gray2bin(input logic [1:0] g);
    gray2bin = {g[1], g[1] ^ g[0]};
  endfunction

  // pause only while four-lane mode is off; lane three is data otherwise
  assign paused = !keep_ff.qe_sync && !lane_in[3];
  assign fifo_empty = (keep_ff.rd_gray == keep_ff.wg_sync);
  assign head_byte = sys_ff.mem[keep_ff.rd_gray[1] ^ keep_ff.rd_gray[0]];
  assign step = lane_step(frame_ff.state == sfl_pkg::ST_DATA ? frame_ff.info.data_lw : frame_ff.info.addr_lw);

  // link side, rising edge: sample lanes, walk the command phases
  always_comb
  begin
    sfl_pkg::sfl_op_info_t dec;
    logic [31:0] sh;
    logic load;
    dec = op_decode(frame_ff.shift[6:0] == 7'h0 ? {frame_ff.shift[6:0], lane_in[0]} : {frame_ff.shift[6:0], lane_in[0]});
    sh = shift_in(frame_ff.shift, frame_ff.info.addr_lw, lane_in);
    load = 1'b0;
    nxt_frame = frame_ff;
    nxt_keep = keep_ff;
    nxt_keep.rst_meta = reset_in;
    nxt_keep.rst_sync = keep_ff.rst_meta;
    nxt_keep.qe_meta = four_lane_enable_in;
    nxt_keep.qe_sync = keep_ff.qe_meta;
    nxt_keep.wg_meta = sys_ff.wgray;
    nxt_keep.wg_sync = keep_ff.wg_meta;
    // a paused frame keeps every counter and ignores the clock
    if (!paused)
    begin
      // one rising edge per falling-to-falling command cycle
      case (frame_ff.state)
        sfl_pkg::ST_OPCODE:
        begin
          nxt_frame.shift = shift_in(frame_ff.shift, sfl_pkg::LW_ONE, lane_in);
          nxt_frame.cnt = frame_ff.cnt + 6'h01;
          if (frame_ff.cnt == sfl_pkg::OPCODE_LAST)
          begin
            nxt_frame.cnt = 6'h00;
            nxt_frame.info = dec;
            nxt_keep.ev.opcode = nxt_frame.shift[7:0];
            nxt_keep.ev.payload = 24'h000000;
            if (dec.is_read && dec.quad && !keep_ff.qe_sync)
            begin
              nxt_frame.state = sfl_pkg::ST_IGNORE;
              nxt_keep.ev.kind = sfl_pkg::EV_REFUSED;
              nxt_keep.ev_toggle = !keep_ff.ev_toggle;
            end
            else if (dec.is_read)
            begin
              nxt_frame.state = sfl_pkg::ST_ADDR;
            end
            else if (nxt_frame.shift[7:0] == sfl_pkg::OP_WRITE_STATUS)
            begin
              nxt_frame.state = sfl_pkg::ST_STATUS;
            end
            else
            begin
              nxt_frame.state = sfl_pkg::ST_IGNORE;
              nxt_keep.ev.kind = sfl_pkg::EV_OPCODE;
              nxt_keep.ev_toggle = !keep_ff.ev_toggle;
            end
          end
        end
        // address and mode byte on one, two or four input lanes
        sfl_pkg::ST_ADDR:
        begin
          nxt_frame.shift = sh;
          nxt_frame.cnt = frame_ff.cnt + step;
          if (nxt_frame.cnt == (frame_ff.info.has_mode ? sfl_pkg::ADDR_MODE_BITS : sfl_pkg::ADDR_BITS))
          begin
            nxt_frame.cnt = 6'h00;
            nxt_keep.ev.kind = sfl_pkg::EV_READ;
            nxt_keep.ev.payload = frame_ff.info.has_mode ? sh[31:8] : sh[23:0];
            nxt_keep.ev_toggle = !keep_ff.ev_toggle;
            if (frame_ff.info.dummy == sfl_pkg::DUMMY_NONE)
            begin
              nxt_frame.state = sfl_pkg::ST_DATA;
              load = 1'b1;
            end
            else
            begin
              nxt_frame.state = sfl_pkg::ST_DUMMY;
            end
          end
        end
        // dummy clocks give the host time to turn its drivers off
        sfl_pkg::ST_DUMMY:
        begin
          nxt_frame.cnt = frame_ff.cnt + 6'h01;
          if (nxt_frame.cnt[3:0] == frame_ff.info.dummy)
          begin
            nxt_frame.cnt = 6'h00;
            nxt_frame.state = sfl_pkg::ST_DATA;
            load = 1'b1;
          end
        end
        // read data leaves two or four bits per clock
        sfl_pkg::ST_DATA:
        begin
          nxt_frame.out_sr = frame_ff.out_sr << step;
          nxt_frame.cnt = frame_ff.cnt + step;
          if (nxt_frame.cnt == sfl_pkg::BYTE_BITS)
          begin
            nxt_frame.cnt = 6'h00;
            load = 1'b1;
          end
        end
        sfl_pkg::ST_STATUS:
        begin
          nxt_frame.shift = shift_in(frame_ff.shift, sfl_pkg::LW_ONE, lane_in);
          nxt_frame.cnt = frame_ff.cnt + 6'h01;
          if (frame_ff.cnt == sfl_pkg::OPCODE_LAST)
          begin
            nxt_frame.state = sfl_pkg::ST_IGNORE;
            nxt_keep.ev.kind = sfl_pkg::EV_STATUS;
            nxt_keep.ev.payload = {16'h0000, nxt_frame.shift[7:0]};
            nxt_keep.ev_toggle = !keep_ff.ev_toggle;
          end
        end
        sfl_pkg::ST_IGNORE:
        begin
          nxt_frame.cnt = 6'h00;
        end
        default:
        begin
          nxt_frame.state = sfl_pkg::ST_IGNORE;
        end
      endcase
    end
    // an empty buffer sends filler rather than stalling the host
    if (load)
    begin
      nxt_frame.out_sr = fifo_empty ? sfl_pkg::UNDERRUN_BYTE : head_byte;
      if (!fifo_empty)
      begin
        nxt_keep.rd_gray = bin2gray(gray2bin(keep_ff.rd_gray) + 2'h1);
      end
    end
    if (keep_ff.rst_sync)
    begin
      nxt_keep.rd_gray = sfl_pkg::PTR_RESET;
      nxt_keep.ev_toggle = 1'b0;
    end
  end

  // frame state restarts whenever chip select is high; works for mode 0 and 3
  always_ff @(posedge link_clk_in or posedge chip_sel_n_in)
  begin
    if (chip_sel_n_in)
    begin
      frame_ff <= '0;
    end
    else
    begin
      frame_ff <= nxt_frame;
    end
  end

  // survives between frames: buffer pointer, event word, synchronisers
  always_ff @(posedge link_clk_in)
  begin
    keep_ff <= nxt_keep;
  end

  // falling edge: drive only the lanes of the data phase
  always_comb
  begin
    nxt_pins.lanes = 4'h0;
    nxt_pins.oe = 4'h0;
    if (frame_ff.state == sfl_pkg::ST_DATA && !paused)
    begin
      case (frame_ff.info.data_lw)
        sfl_pkg::LW_TWO:
        begin
          nxt_pins.lanes = {2'h0, frame_ff.out_sr[7:6]};
          nxt_pins.oe = 4'h3;
        end
        sfl_pkg::LW_FOUR:
        begin
          nxt_pins.lanes = frame_ff.out_sr[7:4];
          nxt_pins.oe = 4'hf;
        end
        default:
        begin
          nxt_pins.lanes = {2'h0, frame_ff.out_sr[7], 1'b0};
          nxt_pins.oe = 4'h2;
        end
      endcase
    end
  end

  // chip select high releases the lanes at once, no clock needed
  always_ff @(negedge link_clk_in or posedge chip_sel_n_in)
  begin
    if (chip_sel_n_in)
    begin
      pins_ff <= '0;
    end
    else
    begin
      pins_ff <= nxt_pins;
    end
  end

  // system side: events, reset and status sequences, buffer fill
  always_comb
  begin
    nxt_sys = sys_ff;
    nxt_sys.tog_meta = keep_ff.ev_toggle;
    nxt_sys.tog_sync = sys_ff.tog_meta;
    nxt_sys.rg_meta = keep_ff.rd_gray;
    nxt_sys.rg_sync = sys_ff.rg_meta;
    nxt_sys.pin_meta = lane_in[3:2];
    nxt_sys.pin_sync = sys_ff.pin_meta;
    nxt_sys.rd_req = 1'b0;
    nxt_sys.soft_reset = 1'b0;
    nxt_sys.nv_wr = 1'b0;
    nxt_sys.refused = 1'b0;
    nxt_sys.wp_n = four_lane_enable_in ? 1'b1 : sys_ff.pin_sync[0];
    nxt_sys.pause = !four_lane_enable_in && !sys_ff.pin_sync[1];
    if (sys_ff.load_pending)
    begin
      nxt_sys.load_pending = 1'b0;
      nxt_sys.sr1 = sr1_nonvolatile_in;
      nxt_sys.vol_active = 1'b0;
    end
    // event word is stable long before its toggle reaches here
    if (sys_ff.tog_sync != sys_ff.tog_seen)
    begin
      nxt_sys.tog_seen = sys_ff.tog_sync;
      nxt_sys.rst_armed = 1'b0;
      nxt_sys.vol_armed = 1'b0;
      case (keep_ff.ev.kind)
        sfl_pkg::EV_OPCODE:
        begin
          nxt_sys.rst_armed = (keep_ff.ev.opcode == sfl_pkg::OP_RESET_ENABLE);
          nxt_sys.vol_armed = (keep_ff.ev.opcode == sfl_pkg::OP_VOLATILE_WREN);
          if (keep_ff.ev.opcode == sfl_pkg::OP_RESET && sys_ff.rst_armed)
          begin
            nxt_sys.soft_reset = 1'b1;
            nxt_sys.load_pending = 1'b1;
          end
        end
        sfl_pkg::EV_READ:
        begin
          nxt_sys.rd_req = 1'b1;
          nxt_sys.rd_opcode = keep_ff.ev.opcode;
          nxt_sys.rd_addr = keep_ff.ev.payload;
        end
        sfl_pkg::EV_STATUS:
        begin
          if (sys_ff.vol_armed)
          begin
            nxt_sys.sr1 = keep_ff.ev.payload[7:0];
            nxt_sys.vol_active = 1'b1;
          end
          else
          begin
            nxt_sys.nv_wr = 1'b1;
            nxt_sys.nv_data = keep_ff.ev.payload[7:0];
          end
        end
        default:
        begin
          nxt_sys.refused = 1'b1;
        end
      endcase
    end
    // buffer write; ready falls as soon as both entries hold data
    if (rd_data_valid_in && sys_ff.fifo_ready)
    begin
      nxt_sys.mem[sys_ff.wgray[1] ^ sys_ff.wgray[0]] = rd_data_in;
      nxt_sys.wgray = bin2gray(gray2bin(sys_ff.wgray) + 2'h1);
    end
    nxt_sys.fifo_ready = (nxt_sys.wgray != ~sys_ff.rg_sync);
  end

  always_ff @(posedge clock_in)
  begin
    if (reset_in)
    begin
      sys_ff <= '0;
      sys_ff.load_pending <= 1'b1;
      sys_ff.fifo_ready <= 1'b1;
      sys_ff.wp_n <= 1'b1;
    end
    else
    begin
      sys_ff <= nxt_sys;
    end
  end

  assign lane_out = pins_ff.lanes;
  assign lane_oe_out = pins_ff.oe;
  assign rd_data_ready_out = sys_ff.fifo_ready;
  assign rd_req_out = sys_ff.rd_req;
  assign rd_opcode_out = sys_ff.rd_opcode;
  assign rd_addr_out = sys_ff.rd_addr;
  assign soft_reset_out = sys_ff.soft_reset;
  assign sr1_out = sys_ff.sr1;
  assign sr1_volatile_out = sys_ff.vol_active;
  assign sr1_nv_wr_out = sys_ff.nv_wr;
  assign sr1_nv_data_out = sys_ff.nv_data;
  assign refused_out = sys_ff.refused;
  assign write_protect_n_out = sys_ff.wp_n;
  assign pause_out = sys_ff.pause;

endmodule
`default_nettype wire

// ### tb/sfl_lane_front_sva.sv
`timescale 1ns/10ps
`default_nettype none
module sfl_lane_front_sva (
  input wire logic clock_in, // system clock
  input wire logic reset_in, // sync reset
  input wire logic chip_sel_n_in, // chip select
  input wire logic [3:0] lane_oe_out, // lane enables
  input wire logic four_lane_enable_in, // four-lane enable
  input wire logic [7:0] sr1_nonvolatile_in, // stored status
  input wire logic rd_req_out, // read event
  input wire logic soft_reset_out, // reset event
  input wire logic [7:0] sr1_out, // active status
  input wire logic sr1_volatile_out, // volatile copy in force
  input wire logic sr1_nv_wr_out, // nv write event
  input wire logic refused_out, // refusal event
  input wire logic write_protect_n_out, // protect level
  input wire logic pause_out // pause level
);
  // link outputs change slowly enough to be judged in the system domain
  default clocking cb @(posedge clock_in);
  endclocking
  default disable iff (reset_in);
  req_spacing_a: assert property (rd_req_out |=> !rd_req_out [*4])
    else $error("read events too close");
  refuse_cause_a: assert property (refused_out |-> !four_lane_enable_in && !rd_req_out)
    else $error("refusal with enable set");
  quad_gate_a: assert property (lane_oe_out == 4'hf |-> four_lane_enable_in)
    else $error("four lanes driven without enable");
  oe_shape_a: assert property (lane_oe_out inside {4'h0, 4'h2, 4'h3, 4'hf})
    else $error("illegal lane enable pattern");
  idle_release_a: assert property (chip_sel_n_in |-> lane_oe_out == 4'h0)
    else $error("lane driven while deselected");
  pins_freed_a: assert property (four_lane_enable_in && $past(four_lane_enable_in) |->
    write_protect_n_out && !pause_out) else $error("shared pins not freed");
  reset_reload_a: assert property (soft_reset_out |=> sr1_out == sr1_nonvolatile_in && !sr1_volatile_out)
    else $error("status not reloaded");
  reset_alone_a: assert property (soft_reset_out |-> !rd_req_out && !sr1_nv_wr_out ##1 !soft_reset_out)
    else $error("reset event malformed");
  nvwr_pulse_a: assert property ($rose(sr1_nv_wr_out) |=> $fell(sr1_nv_wr_out))
    else $error("nv write not one cycle");
endmodule
`default_nettype wire

// ### tb/sfl_host_model.sv
`timescale 1ns/10ps
`default_nettype none
module sfl_host_model (
  input wire logic [3:0] dut_lane_in, // device lane values
  input wire logic [3:0] dut_oe_in, // device lane enables
  output logic link_clk_out, // serial clock, parked per mode
  output logic chip_sel_n_out, // chip select, active low
  output logic [3:0] lane_out, // resolved lane levels
  output logic [23:0] got_out // read bits, top lane first
);
  logic [3:0] h_oe;
  logic [3:0] h_val;
  logic [3:0] tgl;
  logic m3;
  // host lanes released and chip select low at time zero
  initial
  begin
    link_clk_out = 1'b0;
    chip_sel_n_out = 1'b0;
    h_oe = 4'h0;
    h_val = 4'hf;
    tgl = 4'h5;
    m3 = 1'b0;
    got_out = 24'h0;
    // a clean rising edge clears the frame logic before the first frame
    #1 chip_sel_n_out = 1'b1;
  end
  // a released lane wanders every cycle so a stale level cannot pass as data
  assign lane_out = (dut_oe_in & dut_lane_in) | (~dut_oe_in & h_oe & h_val) | (~dut_oe_in & ~h_oe & tgl);
  // one cycle, fall to fall; host changes lanes after the fall, samples at the rise
  task automatic tick(input logic [3:0] oe, input logic [3:0] v, input int lw);
    if (m3)
      link_clk_out = 1'b0;
    h_oe = oe;
    h_val = v;
    tgl = ~tgl;
    #6 link_clk_out = 1'b1;
    for (int j = lw - 1; j >= 0; j--)
      got_out = {got_out[22:0], lane_out[j]};
    #6;
    if (!m3)
      link_clk_out = 1'b0;
  endtask
  // msb first, higher lane carries the more significant bit
  task automatic send(input logic [31:0] d, input logic [7:0] bits, input int lw);
    logic [3:0] v;
    for (int c = 0; c < bits / lw; c++)
    begin
      v = 4'hc;
      for (int j = 0; j < lw; j++)
        v[j] = d[31 - c * lw - (lw - 1 - j)];
      tick((lw == 1) ? 4'hd : 4'hf, v, 0);
    end
  endtask
  task automatic frame(input logic mode3, input logic [7:0] op, input logic [31:0] pl, input logic [7:0] pb,
      input logic [7:0] alw, input logic [7:0] dum, input logic [7:0] dlw, input logic [7:0] db);
    logic [3:0] m;
    m3 = mode3;
    link_clk_out = mode3;
    got_out = 24'h0;
    #20 chip_sel_n_out = 1'b0;
    send({op, 24'h0}, 8'h8, 1);
    send(pl, pb, int'(alw));
    // protect and pause held inactive unless they carry data
    m = (dlw == 8'h4) ? 4'h0 : 4'hc;
    repeat (dum) tick(m, 4'hf, 0);
    repeat (db / dlw) tick(m, 4'hf, int'(dlw));
    #6 chip_sel_n_out = 1'b1;
    h_oe = 4'h0;
    #400;
  endtask
endmodule
`default_nettype wire

// ### tb/sfl_lane_front_tb_top.sv
`timescale 1ns/10ps
`default_nettype none
`define CHK(n, e, s) begin compares++; if ((s) !== (e)) begin fail_count++; $display("Error %s expected %h seen %h", n, e, s); end end
module sfl_lane_front_tb_top;
  logic clock_in, reset_in, en, vld, rdy, sck, csn, rd_req, srst, vol, nvwr, refd, wp_n, pause;
  logic [3:0] lanes, d_lane, d_oe;
  logic [7:0] nv, dat, rd_op, sr1, nvd, s;
  logic [23:0] rd_addr, got;
  logic [35:0] exp_q [$];
  int fail_count, compares, seed;
  event frame_done;
  logic [7:0] qops [4] = '{8'h6b, 8'heb, 8'he7, 8'he3};
  sfl_lane_front DUT (.clock_in(clock_in), .reset_in(reset_in), .link_clk_in(sck), .chip_sel_n_in(csn),
    .lane_in(lanes), .lane_out(d_lane), .lane_oe_out(d_oe), .four_lane_enable_in(en), .sr1_nonvolatile_in(nv),
    .rd_data_valid_in(vld), .rd_data_in(dat), .rd_data_ready_out(rdy), .rd_req_out(rd_req), .rd_opcode_out(rd_op),
    .rd_addr_out(rd_addr), .soft_reset_out(srst), .sr1_out(sr1), .sr1_volatile_out(vol), .sr1_nv_wr_out(nvwr),
    .sr1_nv_data_out(nvd), .refused_out(refd), .write_protect_n_out(wp_n), .pause_out(pause));
  sfl_host_model host (.dut_lane_in(d_lane), .dut_oe_in(d_oe), .link_clk_out(sck), .chip_sel_n_out(csn),
    .lane_out(lanes), .got_out(got));
  always #20 clock_in = ~clock_in;
  task automatic close_out;
    $display("counts: %0d compares, %0d mismatches", compares, fail_count);
    if (fail_count == 0 && compares > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic take(input logic [35:0] v);
    logic [35:0] e;
    e = 36'h0;
    if (exp_q.size() != 0)
      e = exp_q.pop_front();
    `CHK("result", e, v)
  endtask
  // results come back in the order they were noted
  always @(posedge clock_in)
  begin
    if (!reset_in && rd_req === 1'b1)
      take({4'h1, rd_op, rd_addr});
    if (!reset_in && refd === 1'b1)
      take({4'h2, 32'h0});
    if (!reset_in && srst === 1'b1)
      take({4'h3, 32'h0});
    if (!reset_in && nvwr === 1'b1)
      take({4'h4, 24'h0, nvd});
    if (!reset_in && $rose(vol))
      take({4'h5, 24'h0, sr1});
  end
  always @(frame_done) take({4'h6, 8'h0, got});
  // offer one byte; ready is sampled before the edge that takes it
  task automatic put(output logic [7:0] b);
    logic r;
    int k;
    b = 8'($urandom);
    dat = b;
    vld = 1'b1;
    k = 0;
    do
    begin
      r = rdy;
      @(posedge clock_in);
      #2 k++;
    end while (!r && k < 20);
    if (!r)
    begin
      fail_count++;
      close_out();
    end
  endtask
  function automatic logic [31:0] cfg(input logic [7:0] op); // addr lanes, dummy, data lanes, payload bits
    case (op)
      8'h3b: return 32'h01080218;
      8'hbb: return 32'h02000220;
      8'h6b: return 32'h01080418;
      8'heb: return 32'h04040420;
      8'he7: return 32'h04020420;
      default: return 32'h04000420;
    endcase
  endfunction
  // prefill, hold a refused byte while full, then read nb bytes, any past the two-byte fill coming back as filler
  task automatic rd(input logic m, input logic [7:0] op, input int nb);
    logic [31:0] c;
    logic [23:0] a;
    logic [23:0] x;
    logic [7:0] b;
    c = cfg(op);
    a = 24'($urandom);
    @(posedge clock_in);
    #2 x = 24'h0;
    for (int i = 0; i < nb; i++)
    begin
      b = 8'hff;
      if (i < 2)
        put(b);
      x = {x[15:0], b};
    end
    dat = 8'h5a;
    repeat (3) @(posedge clock_in);
    #2 vld = 1'b0;
    `CHK("buffer full", 1'b0, rdy)
    exp_q.push_back({4'h1, op, a});
    exp_q.push_back({4'h6, 8'h0, x});
    host.frame(m, op, {a, 8'h0}, c[7:0], c[31:24], c[23:16], c[15:8], 8'(8 * nb));
    -> frame_done;
    $display("test read %h finished", op);
  endtask
  task automatic cmd(input logic [7:0] op, input logic [7:0] b, input logic [7:0] pb);
    host.frame(1'b0, op, {b, 24'h0}, pb, 8'h1, 8'h0, 8'h1, 8'h0);
  endtask
  initial
  begin
    clock_in = 1'b0;
    reset_in = 1'b1;
    en = 1'b0;
    vld = 1'b0;
    dat = 8'h0;
    seed = $urandom(22);
    nv = 8'($urandom);
    // link clocks during reset clear the link-side pointer and toggle
    fork
      cmd(8'h0, 8'h0, 8'h0);
      begin
        repeat (2) @(posedge clock_in);
        #2 reset_in = 1'b0;
      end
    join
    `CHK("status at start", nv, sr1)
    rd(1'b0, 8'h3b, 3);
    rd(1'b1, 8'hbb, 2);
    @(posedge clock_in);
    #2 en = 1'b1;
    foreach (qops[i]) rd(1'(i), qops[i], 2);
    @(posedge clock_in);
    #2 en = 1'b0;
    exp_q.push_back({4'h2, 32'h0});
    cmd(8'h6b, 8'h12, 8'h8);
    `CHK("protect pin", 1'b1, wp_n)
    `CHK("pause pin", !lanes[3], pause)
    $display("test refusal finished");
    s = 8'($urandom);
    exp_q.push_back({4'h5, 24'h0, s});
    cmd(8'h50, 8'h0, 8'h0);
    cmd(8'h01, s, 8'h8);
    s = 8'($urandom);
    exp_q.push_back({4'h4, 24'h0, s});
    cmd(8'h01, s, 8'h8);
    $display("test status finished");
    cmd(8'h99, 8'h0, 8'h0);
    exp_q.push_back({4'h3, 32'h0});
    cmd(8'h66, 8'h0, 8'h0);
    cmd(8'h99, 8'h0, 8'h0);
    $display("test reset finished");
    for (int k = 0; k < 50 && exp_q.size() != 0; k++)
      @(posedge clock_in);
    if (exp_q.size() != 0)
      fail_count++;
    close_out();
  end
endmodule
bind sfl_lane_front sfl_lane_front_sva chk (.clock_in(clock_in), .reset_in(reset_in), .chip_sel_n_in(chip_sel_n_in),
  .lane_oe_out(lane_oe_out), .four_lane_enable_in(four_lane_enable_in), .sr1_nonvolatile_in(sr1_nonvolatile_in),
  .rd_req_out(rd_req_out), .soft_reset_out(soft_reset_out), .sr1_out(sr1_out), .sr1_volatile_out(sr1_volatile_out),
  .sr1_nv_wr_out(sr1_nv_wr_out), .refused_out(refused_out), .write_protect_n_out(write_protect_n_out),
  .pause_out(pause_out));
`default_nettype wire
